// >>> design/rxoob_pkg.sv
// Package for the receive out-of-band COM detector: register map and fields
package rxoob_pkg;

    // Register byte addresses are four times the printed index
    localparam logic [11:0] IDX_REFCLK_SEL   = 12'hc5c;
    localparam logic [11:0] IDX_PAD_OOB      = 12'hc64;
    localparam logic [11:0] IDX_PCS_TWO      = 12'hc67;
    localparam logic [11:0] IDX_PHY_ZERO     = 12'hc9d;
    localparam logic [11:0] IDX_PHY_ONE      = 12'hc9e;
    localparam logic [11:0] IDX_CLKDIV       = 12'hca3;
    localparam logic [11:0] IDX_FABRIC_TWO   = 12'hcab;
    localparam logic [11:0] IDX_BURST_IDLE   = 12'hcb8;
    localparam logic [11:0] IDX_IDLE_BOUNDS  = 12'hcb9;
    localparam logic [11:0] IDX_RESET_MASK   = 12'hcbb;
    localparam logic [11:0] IDX_STATUS       = 12'hcc0;

    // Field positions
    localparam int IDLE_MODE_LO   = 5;
    localparam int REQ_IDLE_LO    = 27;
    localparam int REQ_BURST_LO   = 24;
    localparam int INIT_MAX_LO    = 18;
    localparam int INIT_MIN_LO    = 12;
    localparam int BURST_MAX_LO   = 6;
    localparam int BURST_MIN_LO   = 0;
    localparam int SAS_MAX_LO     = 18;
    localparam int SAS_MIN_LO     = 12;
    localparam int WAKE_MAX_LO    = 6;
    localparam int WAKE_MIN_LO    = 0;
    localparam int DIVISOR_LO     = 27;
    localparam int REFSEL_BIT     = 19;
    localparam int OOB_RST_BIT    = 25;
    localparam int SPEED_LO       = 30;
    localparam int PD_OVRD_BIT    = 22;
    localparam int PD_BIT         = 21;
    localparam int PWRUP_BIT      = 18;
    localparam int MASK_LO        = 16;
    localparam int MASK_OOB_BIT   = 4;
    localparam int INVERT_BIT     = 24;
    localparam int OVRD_LO        = 19;
    localparam int ERR_REP_BIT    = 31;

    // Reset values
    localparam logic [31:0] BURST_IDLE_RESET = 32'h2400_0000;
    localparam logic [31:0] PWRUP_RESET      = 32'h0004_0000;
    localparam logic [1:0]  IDLE_MODE_DETECT = 2'h0;
    localparam logic [1:0]  IDLE_MODE_STATIC = 2'h3;
    localparam logic [1:0]  OVRD_NORMAL      = 2'h0;
    localparam logic [2:0]  MASK_ALL         = 3'h7;

    typedef enum logic [3:0] {
        RXOOB_IDLE  = 4'b0001,
        RXOOB_BURST = 4'b0010,
        RXOOB_GAP   = 4'b0100,
        RXOOB_DONE  = 4'b1000
    } rxoob_fsm_t;

    // Gap classification
    typedef struct packed {
        logic init;
        logic wake;
        logic sas;
    } rxoob_kind_t;

    typedef struct packed {
        logic [31:0] refsel;
        logic [31:0] pad;
        logic [31:0] pcs;
        logic [31:0] phy0;
        logic [31:0] phy1;
        logic [31:0] clkdiv;
        logic [31:0] fab;
        logic [31:0] cfg0;
        logic [31:0] cfg1;
        logic [31:0] rmask;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rxoob_regs_t;

    typedef struct packed {
        rxoob_fsm_t  fsm;
        logic [4:0]  div_cnt;
        logic        tick;
        logic        act_q;
        logic        act_seen;
        logic [6:0]  len;
        logic [2:0]  bursts;
        logic [2:0]  idles;
        rxoob_kind_t kind;
        logic        line_idle;
        rxoob_kind_t seen;
        logic        oob_rst_q;
        logic        oob_rst;
        logic        powered;
    } rxoob_core_t;

endpackage

// >>> design/rxoob_detector.sv
// Receive out-of-band COM sequence detector with APB register file
// Overview of operation
// R1: Line-idle output low on activity, high when no activity detected.
// R2: Idle-report mode 00 drives line-idle from the detection circuit.
// R3: Idle-report mode 11 holds line-idle output at constant zero.
// R4: Three detect outputs: init/reset, wake and SAS sequence seen.
// R5: Declare a match only after configured burst count, field 26:24.
// R6: Also require configured idle gap count, field 29:27.
// R7: Init gap valid only between bounds at bits 17:12 and 23:18.
// R8: Burst accepted only when length is between bits 5:0 and 11:6.
// R9: SAS gap valid only between second-word bounds 17:12 and 24:18.
// R10: Wake gap valid only between second-word bounds 5:0 and 11:6.
// R11: Detection tick is reference clock divided by field 31:27 plus one.
// R12: Select bit 19 picks ring or LC PLL reference clock.
// R13: OOB reset pulse restarts detection regardless of reset mask.
// R14: Speed field 31:30 selects SATA gen one to three or SAS 12G.
// R15: Override bit 22 takes power-down state from bit 21.
// R16: Power-up bit 18 low powers the detector down.
// R17: Mask field 20:16 selects sub-resets; bit 4 is the OOB one.
// R18: Bit 24 inverts the detection threshold polarity.
// R19: Override field 20:19 substitutes the programmed override value.
// R20: Bit 31 of PCS word disables erroneous symbol replacement.
// R21: Controller should freeze clock recovery during initial idle.
// R22: Controller must not use line-idle alone above 2.5 Gb/s.
// R23: Count in the divided domain; present each detect as one pulse.
`timescale 1ns/1ps
`default_nettype none

module rxoob_detector
    import rxoob_pkg::*;
#(
    parameter int LEN_W = 7
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        line_activity,
    input  wire logic        oob_only_reset,
    input  wire logic        ring_pll_present,
    input  wire logic        lc_tank_pll_present,
    input  wire logic        subsys_pcs_reset,
    output logic             line_idle_status,
    output logic             init_sequence_seen,
    output logic             wake_sequence_seen,
    output logic             sas_sequence_seen,
    output logic             detector_enabled,
    output logic [1:0]       link_generation_select,
    output logic             symbol_error_replace_disable,
    output logic [4:0]       receive_subreset_mask
);
    import rxoob_pkg::*;

    rxoob_regs_t r_reg, r_next;
    rxoob_core_t c_reg, c_next;

    // Field views of the configuration words
    logic [1:0] idle_report_mode;
    logic [2:0] required_idle_count, required_burst_count;
    logic [5:0] init_gap_upper_bound, init_gap_lower_bound;
    logic [5:0] burst_len_upper_bound, burst_len_lower_bound;
    logic [6:0] sas_gap_upper_bound;
    logic [5:0] sas_gap_lower_bound;
    logic [5:0] wake_gap_upper_bound, wake_gap_lower_bound;
    logic [4:0] detect_clock_divisor;
    logic       detect_refclk_source, refclk_ok;
    logic       detector_powerdown, detector_powerup, powered;
    logic       threshold_polarity_invert;
    logic [1:0] oob_override;
    logic       act_raw, act_eff, oob_reset_attr_bit, oob_masked;
    logic [11:0] idx;
    logic       wr_en, rd_en;

    assign idle_report_mode      = r_reg.phy0[IDLE_MODE_LO +: 2];
    assign required_idle_count   = r_reg.cfg0[REQ_IDLE_LO +: 3];   // R6
    assign required_burst_count  = r_reg.cfg0[REQ_BURST_LO +: 3];  // R5
    assign init_gap_upper_bound  = r_reg.cfg0[INIT_MAX_LO +: 6];
    assign init_gap_lower_bound  = r_reg.cfg0[INIT_MIN_LO +: 6];
    assign burst_len_upper_bound = r_reg.cfg0[BURST_MAX_LO +: 6];
    assign burst_len_lower_bound = r_reg.cfg0[BURST_MIN_LO +: 6];
    assign sas_gap_upper_bound   = r_reg.cfg1[SAS_MAX_LO +: 7];
    assign sas_gap_lower_bound   = r_reg.cfg1[SAS_MIN_LO +: 6];
    assign wake_gap_upper_bound  = r_reg.cfg1[WAKE_MAX_LO +: 6];
    assign wake_gap_lower_bound  = r_reg.cfg1[WAKE_MIN_LO +: 6];
    assign detect_clock_divisor  = r_reg.clkdiv[DIVISOR_LO +: 5];
    assign detect_refclk_source  = r_reg.refsel[REFSEL_BIT];
    assign detector_powerdown    = r_reg.phy1[PD_BIT];
    assign detector_powerup      = r_reg.pad[PWRUP_BIT];
    assign threshold_polarity_invert = r_reg.pad[INVERT_BIT];
    assign oob_override          = r_reg.pad[OVRD_LO +: 2];
    assign oob_reset_attr_bit    = r_reg.fab[OOB_RST_BIT];
    assign oob_masked            = r_reg.rmask[MASK_LO + MASK_OOB_BIT];

    // Reference source: ring PLL on 0, LC tank PLL on 1
    assign refclk_ok = detect_refclk_source ? lc_tank_pll_present
                                            : ring_pll_present; // R12

    // Override bit hands power-down to software; power-up bit and reference clock presence always gate too
    assign powered = (r_reg.phy1[PD_OVRD_BIT] ? ~detector_powerdown
                                               : 1'b1)          // R15
                     & detector_powerup & refclk_ok;           // R16

    // Threshold inversion flips the sensed level; override replaces it
    assign act_raw = line_activity ^ threshold_polarity_invert; // R18
    assign act_eff = (oob_override == OVRD_NORMAL) ? act_raw
                   : oob_override[1];                           // R19

    assign idx   = paddr[13:2];
    assign wr_en = psel & penable & pwrite & ~r_reg.pready;
    assign rd_en = psel & ~penable & ~pwrite;

    // APB slave: one wait state, error on unmapped index
    always_comb begin
        r_next = r_reg;
        r_next.pready  = psel & penable & ~r_reg.pready;
        r_next.pslverr = 1'b0;
        if (rd_en) begin
            r_next.prdata = 32'h0000_0000;
            unique case (idx)
                IDX_REFCLK_SEL:  r_next.prdata = r_reg.refsel;
                IDX_PAD_OOB:     r_next.prdata = r_reg.pad;
                IDX_PCS_TWO:     r_next.prdata = r_reg.pcs;
                IDX_PHY_ZERO:    r_next.prdata = r_reg.phy0;
                IDX_PHY_ONE:     r_next.prdata = r_reg.phy1;
                IDX_CLKDIV:      r_next.prdata = r_reg.clkdiv;
                IDX_FABRIC_TWO:  r_next.prdata = r_reg.fab;
                IDX_BURST_IDLE:  r_next.prdata = r_reg.cfg0;
                IDX_IDLE_BOUNDS: r_next.prdata = r_reg.cfg1;
                IDX_RESET_MASK:  r_next.prdata = r_reg.rmask;
                IDX_STATUS: begin
                    r_next.prdata = {25'h0, c_reg.bursts, c_reg.line_idle,
                                     c_reg.fsm == RXOOB_BURST, powered,
                                     refclk_ok};
                end
                default: begin
                end
            endcase
        end
        if (psel & penable & ~r_reg.pready) begin
            unique case (idx)
                IDX_REFCLK_SEL, IDX_PAD_OOB, IDX_PCS_TWO, IDX_PHY_ZERO,
                IDX_PHY_ONE, IDX_CLKDIV, IDX_FABRIC_TWO, IDX_BURST_IDLE,
                IDX_IDLE_BOUNDS, IDX_RESET_MASK, IDX_STATUS: begin
                end
                default: r_next.pslverr = 1'b1;
            endcase
        end
        if (wr_en) begin
            unique case (idx)
                IDX_REFCLK_SEL:  r_next.refsel = pwdata;
                IDX_PAD_OOB:     r_next.pad    = pwdata;
                IDX_PCS_TWO:     r_next.pcs    = pwdata;
                IDX_PHY_ZERO:    r_next.phy0   = pwdata;
                IDX_PHY_ONE:     r_next.phy1   = pwdata;
                IDX_CLKDIV:      r_next.clkdiv = pwdata;
                IDX_FABRIC_TWO:  r_next.fab    = pwdata;
                IDX_BURST_IDLE:  r_next.cfg0   = pwdata;
                IDX_IDLE_BOUNDS: r_next.cfg1   = pwdata;
                IDX_RESET_MASK:  r_next.rmask  = pwdata;
                default: begin
                end
            endcase
        end
        // Clear once the request is seen, or it could never fall
        if (c_reg.oob_rst_q & ~(wr_en && idx == IDX_FABRIC_TWO)) begin
            r_next.fab[OOB_RST_BIT] = 1'b0;
        end
    end

    // Detection core running on the divided tick
    always_comb begin
        logic       reset_core;
        logic       burst_ok;
        logic [6:0] len_next;
        reset_core = 1'b0;
        burst_ok   = 1'b0;
        len_next   = 7'h00;
        c_next = c_reg;
        c_next.seen = '0;
        c_next.powered = powered;  // Registered for the status pin
        c_next.oob_rst_q = oob_only_reset | oob_reset_attr_bit;
        // Falling edge of the reset request restarts the detector
        c_next.oob_rst = c_reg.oob_rst_q
                       & ~(oob_only_reset | oob_reset_attr_bit); // R13
        // Mask bit only gates the shared subsystem reset, never ours
        reset_core = c_reg.oob_rst | ~powered
                   | (subsys_pcs_reset & oob_masked);          // R13 R17
        // Tick every divisor plus one clocks, 50 MHz with the bench's divisor of one
        c_next.tick = 1'b0;
        if (c_reg.div_cnt >= detect_clock_divisor) begin
            c_next.div_cnt = 5'h00;
            c_next.tick    = 1'b1;                               // R11
        end else begin
            c_next.div_cnt = c_reg.div_cnt + 5'h01;
        end
        // Latch activity between ticks so short bursts are not missed
        c_next.act_seen = c_reg.act_seen | act_eff;
        // Line idle follows detection in mode 00, is held low in mode 11, else keeps its value
        if (idle_report_mode == IDLE_MODE_STATIC) begin
            c_next.line_idle = 1'b0;                             // R3
        end else if (idle_report_mode == IDLE_MODE_DETECT) begin
            c_next.line_idle = ~act_eff & powered;               // R1 R2
        end
        len_next = (c_reg.len == 7'h7f) ? c_reg.len : c_reg.len + 7'h01;
        if (c_reg.tick) begin                                    // R23
            c_next.act_seen = act_eff;
            c_next.act_q    = c_reg.act_seen;
            burst_ok = c_reg.len[5:0] >= burst_len_lower_bound
                     && c_reg.len <= {1'b0, burst_len_upper_bound}; // R8
            unique case (c_reg.fsm)
                RXOOB_IDLE: begin
                    c_next.len = 7'h00;
                    c_next.bursts = 3'h0;
                    c_next.idles  = 3'h0;
                    if (c_reg.act_seen) begin
                        c_next.fsm = RXOOB_BURST;
                    end
                end
                RXOOB_BURST: begin
                    if (c_reg.act_seen) begin
                        c_next.len = len_next;
                    end else if (burst_ok) begin
                        c_next.bursts = c_reg.bursts + 3'h1;     // R5
                        c_next.len = 7'h00;
                        c_next.fsm = RXOOB_GAP;
                    end else begin
                        c_next.fsm = RXOOB_IDLE;
                    end
                end
                RXOOB_GAP: begin
                    if (!c_reg.act_seen) begin
                        c_next.len = len_next;
                    end else begin
                        c_next.kind.init =
                            c_reg.len >= {1'b0, init_gap_lower_bound} &&
                            c_reg.len <= {1'b0, init_gap_upper_bound}; // R7
                        c_next.kind.sas =
                            c_reg.len >= {1'b0, sas_gap_lower_bound} &&
                            c_reg.len <= sas_gap_upper_bound;      // R9
                        c_next.kind.wake =
                            c_reg.len >= {1'b0, wake_gap_lower_bound} &&
                            c_reg.len <= {1'b0, wake_gap_upper_bound}; // R10
                        c_next.len = 7'h00;
                        if (c_next.kind == '0 ||
                            (c_reg.idles != 3'h0 &&
                             c_next.kind != c_reg.kind)) begin
                            c_next.fsm = RXOOB_IDLE;
                        end else begin
                            c_next.idles = c_reg.idles + 3'h1;   // R6
                            c_next.fsm = RXOOB_BURST;
                        end
                        // Enough bursts and gaps: declare the match
                        if (c_reg.bursts >= required_burst_count &&
                            c_reg.idles + 3'h1 >= required_idle_count &&
                            c_next.fsm == RXOOB_BURST) begin
                            c_next.fsm = RXOOB_DONE;
                        end
                    end
                    // A long silence ends the sequence too
                    if (c_reg.len == 7'h7f) begin
                        c_next.fsm = RXOOB_IDLE;
                    end
                end
                RXOOB_DONE: begin
                    c_next.seen = c_reg.kind;                    // R4
                    c_next.fsm  = RXOOB_IDLE;
                end
                default: c_next.fsm = RXOOB_IDLE;
            endcase
        end
        if (reset_core) begin
            c_next.fsm    = RXOOB_IDLE;
            c_next.len    = 7'h00;
            c_next.bursts = 3'h0;
            c_next.idles  = 3'h0;
            c_next.kind   = '0;
            c_next.seen   = '0;
        end
    end

    // Single state update
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r_reg <= '0;
            r_reg.cfg0 <= BURST_IDLE_RESET;
            r_reg.pad  <= PWRUP_RESET;
            c_reg <= '0;
            c_reg.fsm <= RXOOB_IDLE;
        end else begin
            r_reg <= r_next;
            c_reg <= c_next;
        end
    end

    // Outputs straight from flip-flops
    assign prdata  = r_reg.prdata;
    assign pready  = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign line_idle_status   = c_reg.line_idle;
    assign init_sequence_seen = c_reg.seen.init;
    assign wake_sequence_seen = c_reg.seen.wake;
    assign sas_sequence_seen  = c_reg.seen.sas;
    assign detector_enabled   = c_reg.powered;                  // R15 R16
    assign link_generation_select = r_reg.phy1[SPEED_LO +: 2];     // R14
    assign symbol_error_replace_disable = r_reg.pcs[ERR_REP_BIT];  // R20
    assign receive_subreset_mask = r_reg.rmask[MASK_LO +: 5];      // R17

    // Assertions
    a_static_idle_low: assert property (@(posedge clk) disable iff (!reset_n)
        idle_report_mode == IDLE_MODE_STATIC |=> !line_idle_status)
        else $error("line idle not low in static mode"); // R3
    a_idle_follows: assert property (@(posedge clk) disable iff (!reset_n)
        (idle_report_mode == IDLE_MODE_DETECT && act_eff)
        |=> !line_idle_status)
        else $error("line idle high during activity"); // R1
    a_seen_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        init_sequence_seen |=> !init_sequence_seen)
        else $error("detect not a single pulse"); // R23
    a_seen_from_done: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(wake_sequence_seen) |-> $past(c_reg.fsm) == RXOOB_DONE)
        else $error("detect without completed sequence"); // R4
    a_tick_period: assert property (@(posedge clk) disable iff (!reset_n)
        c_reg.tick && detect_clock_divisor == 5'h01 && $stable(r_reg.clkdiv)
        |=> !c_reg.tick ##1 c_reg.tick)
        else $error("divided tick period wrong"); // R11
    a_oob_restart: assert property (@(posedge clk) disable iff (!reset_n)
        c_reg.oob_rst |=> c_reg.fsm == RXOOB_IDLE && c_reg.bursts == 3'h0)
        else $error("oob reset did not restart"); // R13
    a_power_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !detector_powerup |=> c_reg.fsm == RXOOB_IDLE)
        else $error("detector ran while powered down"); // R16
    a_burst_count: assert property (@(posedge clk) disable iff (!reset_n)
        c_reg.fsm == RXOOB_DONE |-> c_reg.bursts >= required_burst_count)
        else $error("match with too few bursts"); // R5
    a_idle_count: assert property (@(posedge clk) disable iff (!reset_n)
        c_reg.fsm == RXOOB_DONE |-> c_reg.idles >= required_idle_count)
        else $error("match with too few gaps"); // R6

endmodule

`default_nettype wire

// >>> verif/rxoob_line_model.sv
// Far-end serial transmitter model: OOB bursts and idle gaps
`timescale 1ns/1ps
`default_nettype none

module rxoob_line_model (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [7:0] burst_len,
    input  wire logic [7:0] gap_len,
    input  wire logic [2:0] n_bursts,
    output var logic        line_activity,
    output var logic        busy
);
    // Line rests in electrical idle between frames; lengths in clocks
    initial begin
        line_activity = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (start === 1'b1) begin
                busy <= 1'b1;
                for (int b = 0; b < int'(n_bursts); b++) begin
                    if (b != 0) begin
                        repeat (gap_len) @(posedge clk);
                    end
                    line_activity <= 1'b1;
                    repeat (burst_len) @(posedge clk);
                    line_activity <= 1'b0;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/rxoob_detector_tb_top.sv
// Self-checking bench: register access and COM detection
`timescale 1ns/1ps
`default_nettype none

module rxoob_detector_tb_top;
    import rxoob_pkg::*;

    typedef struct packed {
        logic [11:0] idx;
        logic [31:0] data;
        logic [8:0]  msk;
        logic [8:0]  exp;
    } rxoob_row_t;

    logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic        oob_rst = 0, ring_ok = 1, lc_ok = 1, pcs_rst = 0, start = 0;
    logic [7:0]  burst_len = '0, gap_len = '0;
    logic [2:0]  n_bursts = '0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, act, busy, err, idle_st, en, err_dis;
    logic        init_p, wake_p, sas_p;
    logic [1:0]  gen;
    logic [4:0]  rmask;
    logic [8:0]  obs;
    int          miscompares = 0, n_compared = 0;
    int          cnt_init = 0, cnt_wake = 0, cnt_sas = 0;
    rxoob_row_t  rows [16];
    logic [21:0] seqs [5];

    rxoob_detector uut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_activity(act),
        .oob_only_reset(oob_rst), .ring_pll_present(ring_ok),
        .lc_tank_pll_present(lc_ok), .subsys_pcs_reset(pcs_rst),
        .line_idle_status(idle_st), .init_sequence_seen(init_p),
        .wake_sequence_seen(wake_p), .sas_sequence_seen(sas_p),
        .detector_enabled(en), .link_generation_select(gen),
        .symbol_error_replace_disable(err_dis),
        .receive_subreset_mask(rmask)
    );

    rxoob_line_model line (
        .clk(clk), .start(start), .burst_len(burst_len),
        .gap_len(gap_len), .n_bursts(n_bursts), .line_activity(act),
        .busy(busy)
    );

    assign obs = {en, gen, rmask, err_dis};

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Pulse counters; a detect stuck high counts every cycle
    always @(posedge clk) begin
        cnt_init <= cnt_init + int'(init_p === 1'b1);
        cnt_wake <= cnt_wake + int'(wake_p === 1'b1);
        cnt_sas  <= cnt_sas + int'(sas_p === 1'b1);
    end

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; pready sampled at the rising edge
    task automatic apb(input logic wr, input logic [11:0] idx,
                       input logic [31:0] wd, output logic [31:0] rdat,
                       output logic serr);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                miscompares++;
                conclude();
            end
            @(posedge clk);
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Send one burst train, wait a quiet window, then count detects since the start
    task automatic run_seq(input logic [21:0] s);
        int b0, b1, b2, n;
        b0 = cnt_init;
        b1 = cnt_wake;
        b2 = cnt_sas;
        @(posedge clk);
        {burst_len, gap_len, n_bursts} <= s[21:3];
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        @(negedge clk);
        while (busy === 1'b1) begin
            n++;
            if (n > 2000) begin
                miscompares++;
                conclude();
            end
            @(negedge clk);
        end
        repeat (200) @(negedge clk);
        check({8'(cnt_init - b0), 8'(cnt_wake - b1), 8'(cnt_sas - b2)},
              {7'd0, s[2], 7'd0, s[1], 7'd0, s[0]});
    endtask

    initial begin
        // Register rows: index, data, observed-field mask, expected fields
        rows = '{{IDX_PHY_ONE, 32'hc000_0000, 9'h0c0, 9'h0c0},
                 {IDX_PHY_ONE, 32'h8000_0000, 9'h0c0, 9'h080},
                 {IDX_PHY_ONE, 32'h4060_0000, 9'h1c0, 9'h040},
                 {IDX_PHY_ONE, 32'h0040_0000, 9'h1c0, 9'h100},
                 {IDX_PHY_ONE, 32'h0000_0000, 9'h1c0, 9'h100},
                 {IDX_PAD_OOB, 32'h0000_0000, 9'h100, 9'h000},
                 {IDX_PAD_OOB, 32'h0004_0000, 9'h100, 9'h100},
                 {IDX_RESET_MASK, 32'h001f_0000, 9'h03e, 9'h03e},
                 {IDX_RESET_MASK, 32'h0005_0000, 9'h03e, 9'h00a},
                 {IDX_PCS_TWO, 32'h8000_0000, 9'h001, 9'h001},
                 {IDX_PCS_TWO, 32'h0000_0000, 9'h001, 9'h000},
                 {IDX_REFCLK_SEL, 32'h0008_0000, 9'h100, 9'h100},
                 {IDX_CLKDIV, 32'h0800_0000, 9'h000, 9'h000},
                 {IDX_BURST_IDLE, 32'h2450_a204, 9'h000, 9'h000},
                 {IDX_IDLE_BOUNDS, 32'h00a1_e182, 9'h000, 9'h000},
                 {IDX_PHY_ZERO, 32'h0000_0000, 9'h000, 9'h000}};
        // Trains in clocks (tick is two clocks): burst, gap, count, kinds
        seqs = '{{8'd12, 8'd30, 3'd5, 3'b100},
                 {8'd12, 8'd8, 3'd5, 3'b010},
                 {8'd12, 8'd70, 3'd5, 3'b001},
                 {8'd30, 8'd30, 3'd5, 3'b000},
                 {8'd12, 8'd30, 3'd3, 3'b000}};
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, IDX_BURST_IDLE, '0, rd, err);
        check(rd, BURST_IDLE_RESET);
        apb(1'b0, IDX_PAD_OOB, '0, rd, err);
        check(rd[18], PWRUP_RESET[18]);
        // Unmapped index is refused and reads as zero
        apb(1'b1, 12'h000, 32'hffff_ffff, rd, err);
        apb(1'b0, 12'h000, '0, rd, err);
        check({err, rd[30:0]}, 32'h8000_0000);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].idx, rows[i].data, rd, err);
            apb(1'b0, rows[i].idx, '0, rd, err);
            check(rd, rows[i].data);
            check(obs & rows[i].msk, rows[i].exp);
        end
        check(idle_st, 1'b1);
        foreach (seqs[i]) begin
            run_seq(seqs[i]);
        end
        // Shared sub-reset is masked off for the detector here
        pcs_rst <= 1'b1;
        run_seq(seqs[0]);
        pcs_rst <= 1'b0;
        // Activity shows as low idle status in mid-burst
        fork
            run_seq({8'd30, 8'd30, 3'd1, 3'b000});
            begin
                repeat (14) @(negedge clk);
                check(idle_st, 1'b0);
            end
        join
        // Restart in mid-train leaves too few bursts for a match
        fork
            run_seq({seqs[0][21:3], 3'b000});
            begin
                repeat (100) @(posedge clk);
                oob_rst <= 1'b1;
                repeat (3) @(posedge clk);
                oob_rst <= 1'b0;
            end
        join
        // Inverted threshold reads a quiet line as activity
        apb(1'b1, IDX_PAD_OOB, 32'h0104_0000, rd, err);
        repeat (8) @(negedge clk);
        check(idle_st, 1'b0);
        // Debug override forces activity, then forces quiet
        apb(1'b1, IDX_PAD_OOB, 32'h0014_0000, rd, err);
        repeat (8) @(negedge clk);
        check(idle_st, 1'b0);
        apb(1'b1, IDX_PAD_OOB, 32'h000c_0000, rd, err);
        repeat (8) @(negedge clk);
        check(idle_st, 1'b1);
        apb(1'b1, IDX_PHY_ZERO, 32'h0000_0060, rd, err);
        repeat (4) @(negedge clk);
        check(idle_st, 1'b0);
        lc_ok <= 1'b0;
        repeat (4) @(negedge clk);
        check(en, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
